// *** inc/dgpio_defs.svh ***
`ifndef DGPIO_DEFS_SVH
`define DGPIO_DEFS_SVH

// Bus geometry.
`define DGPIO_ADDR_W      6
`define DGPIO_DATA_W      32
`define DGPIO_BYTE_W      8
`define DGPIO_PAD_W       24
`define DGPIO_IDX_MSB     5
`define DGPIO_IDX_LSB     2

// Register indices; the byte address is four times the index.
`define DGPIO_IDX_PE_DATA 4'h8
`define DGPIO_IDX_PF_DATA 4'ha
`define DGPIO_IDX_PF_DIR  4'hb
`define DGPIO_IDX_PE_DIR  4'hc
`define DGPIO_IDX_PE_LED  4'he
`define DGPIO_IDX_PF_LED  4'hf

// Reset values.
`define DGPIO_DIR_RST     8'h00
`define DGPIO_LED_RST     8'h00
`define DGPIO_PIN_RST     8'h00

// Bus responses.
`define DGPIO_RESP_OKAY   2'h0
`define DGPIO_RESP_SLVERR 2'h2

`endif

// *** inc/dgpio_pkg.sv ***
package dgpio_pkg;

  typedef logic [7:0] dgpio_byte_type;

  // Output pins read their latch, input pins read the sampled pin level.
  function automatic dgpio_byte_type dgpio_read_mux(input dgpio_byte_type dir,
                                                    input dgpio_byte_type latch,
                                                    input dgpio_byte_type pin);
    dgpio_read_mux = (dir & latch) | (~dir & pin);
  endfunction

endpackage

// *** inc/dgpio_port_if.sv ***
interface dgpio_port_if;
  dgpio_pkg::dgpio_byte_type wr_data;
  logic                      wr_latch;
  logic                      wr_dir;
  logic                      wr_led;
  logic                      alt_sel;
  dgpio_pkg::dgpio_byte_type alt_data;
  dgpio_pkg::dgpio_byte_type pin_in;
  dgpio_pkg::dgpio_byte_type rd_value;
  dgpio_pkg::dgpio_byte_type dir;
  dgpio_pkg::dgpio_byte_type led;
  dgpio_pkg::dgpio_byte_type pin_out;
  dgpio_pkg::dgpio_byte_type pin_oe;
  dgpio_pkg::dgpio_byte_type led_drive;

  modport ctrl (
    output wr_data, wr_latch, wr_dir, wr_led, alt_sel, alt_data, pin_in,
    input  rd_value, dir, led, pin_out, pin_oe, led_drive
  );

  modport port (
    input  wr_data, wr_latch, wr_dir, wr_led, alt_sel, alt_data, pin_in,
    output rd_value, dir, led, pin_out, pin_oe, led_drive
  );
endinterface

// *** logic/dgpio_port.sv ***
`include "dgpio_defs.svh"

module dgpio_port (
  input wire logic   clk,
  input wire logic   rstn,
  dgpio_port_if.port bus
);

  dgpio_pkg::dgpio_byte_type latch_q;
  dgpio_pkg::dgpio_byte_type dir_q;
  dgpio_pkg::dgpio_byte_type led_q;
  dgpio_pkg::dgpio_byte_type out_q;
  dgpio_pkg::dgpio_byte_type oe_q;
  dgpio_pkg::dgpio_byte_type drive_q;

  ////////////////////////////////////////////////////////////////////////////
  // The data latch has no reset so that its contents survive a reset.
  always_ff @(posedge clk)
  begin
    if (bus.wr_latch)
    begin
      latch_q <= bus.wr_data;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      dir_q <= `DGPIO_DIR_RST;
    end
    else if (bus.wr_dir)
    begin
      dir_q <= bus.wr_data;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      led_q <= `DGPIO_LED_RST;
    end
    else if (bus.wr_led)
    begin
      led_q <= bus.wr_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers; the alternate function takes every pin of the port.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      out_q   <= `DGPIO_PIN_RST;
      oe_q    <= `DGPIO_PIN_RST;
      drive_q <= `DGPIO_PIN_RST;
    end
    else
    begin
      out_q   <= bus.alt_sel ? bus.alt_data : latch_q;
      oe_q    <= bus.alt_sel ? {`DGPIO_BYTE_W{1'b1}} : dir_q;
      drive_q <= bus.alt_sel ? `DGPIO_PIN_RST : led_q;
    end
  end

  assign bus.rd_value  = dgpio_pkg::dgpio_read_mux(dir_q, latch_q, bus.pin_in);
  assign bus.dir       = dir_q;
  assign bus.led       = led_q;
  assign bus.pin_out   = out_q;
  assign bus.pin_oe    = oe_q;
  assign bus.led_drive = drive_q;

endmodule

// *** logic/dgpio_top.sv ***
`include "dgpio_defs.svh"

module dgpio_top (
  input  wire logic                      clk,
  input  wire logic                      rstn,
  input  wire logic [`DGPIO_ADDR_W-1:0]  awaddr,
  input  wire logic [2:0]                awprot,
  input  wire logic                      awvalid,
  output logic                           awready,
  input  wire logic [`DGPIO_DATA_W-1:0]  wdata,
  input  wire logic [3:0]                wstrb,
  input  wire logic                      wvalid,
  output logic                           wready,
  output logic [1:0]                     bresp,
  output logic                           bvalid,
  input  wire logic                      bready,
  input  wire logic [`DGPIO_ADDR_W-1:0]  araddr,
  input  wire logic [2:0]                arprot,
  input  wire logic                      arvalid,
  output logic                           arready,
  output logic [`DGPIO_DATA_W-1:0]       rdata,
  output logic [1:0]                     rresp,
  output logic                           rvalid,
  input  wire logic                      rready,
  input  wire logic                      lcd_frontplane_select,
  input  wire logic [`DGPIO_BYTE_W-1:0]  lcd_frontplane_outputs,
  input  wire logic [`DGPIO_BYTE_W-1:0]  port_e_pin_in,
  output logic [`DGPIO_BYTE_W-1:0]       port_e_pin_out,
  output logic [`DGPIO_BYTE_W-1:0]       port_e_pin_oe,
  output logic [`DGPIO_BYTE_W-1:0]       port_e_led_drive,
  input  wire logic [`DGPIO_BYTE_W-1:0]  port_f_pin_in,
  output logic [`DGPIO_BYTE_W-1:0]       port_f_pin_out,
  output logic [`DGPIO_BYTE_W-1:0]       port_f_pin_oe,
  output logic [`DGPIO_BYTE_W-1:0]       port_f_led_drive
);

  dgpio_port_if pe_if ();
  dgpio_port_if pf_if ();

  logic                          awready_q;
  logic                          wready_q;
  logic                          aw_got_q;
  logic                          w_got_q;
  logic [`DGPIO_ADDR_W-1:0]      awaddr_q;
  dgpio_pkg::dgpio_byte_type     wdata_q;
  logic                          wlane_q;
  logic                          bvalid_q;
  logic [1:0]                    bresp_q;
  logic                          arready_q;
  logic                          rvalid_q;
  logic [1:0]                    rresp_q;
  logic [`DGPIO_DATA_W-1:0]      rdata_q;
  logic                          aw_take;
  logic                          w_take;
  logic                          ar_take;
  logic                          do_write;
  logic                          bvalid_d;
  logic                          rvalid_d;
  logic [3:0]                    wr_idx;
  logic [3:0]                    rd_idx;
  logic                          wr_hit;
  logic                          wr_en;
  logic                          rd_hit;
  dgpio_pkg::dgpio_byte_type     rd_val;

  ////////////////////////////////////////////////////////////////////////////
  // Write channels: address and data are held until both are in.
  assign aw_take  = awvalid & awready_q;
  assign w_take   = wvalid & wready_q;
  assign do_write = aw_got_q & w_got_q & ~bvalid_q;
  assign bvalid_d = do_write | (bvalid_q & ~bready);
  assign wr_idx   = awaddr_q[`DGPIO_IDX_MSB:`DGPIO_IDX_LSB];

  always_comb
  begin
    case (wr_idx)
      `DGPIO_IDX_PE_DATA,
      `DGPIO_IDX_PF_DATA,
      `DGPIO_IDX_PF_DIR,
      `DGPIO_IDX_PE_DIR,
      `DGPIO_IDX_PE_LED,
      `DGPIO_IDX_PF_LED: wr_hit = 1'b1;
      default:           wr_hit = 1'b0;
    endcase
  end

  // A mapped write with the low byte lane off changes nothing but still answers OKAY.
  assign wr_en = do_write & wr_hit & wlane_q;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      aw_got_q <= 1'b0;
      awaddr_q <= '0;
    end
    else if (aw_take)
    begin
      aw_got_q <= 1'b1;
      awaddr_q <= awaddr;
    end
    else if (do_write)
    begin
      aw_got_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      w_got_q <= 1'b0;
      wdata_q <= '0;
      wlane_q <= 1'b0;
    end
    else if (w_take)
    begin
      w_got_q <= 1'b1;
      wdata_q <= wdata[`DGPIO_BYTE_W-1:0];
      wlane_q <= wstrb[0];
    end
    else if (do_write)
    begin
      w_got_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      awready_q <= 1'b0;
    end
    else
    begin
      awready_q <= ~aw_take & ~(aw_got_q & ~do_write) & ~bvalid_d;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wready_q <= 1'b0;
    end
    else
    begin
      wready_q <= ~w_take & ~(w_got_q & ~do_write) & ~bvalid_d;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      bvalid_q <= 1'b0;
    end
    else
    begin
      bvalid_q <= bvalid_d;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      bresp_q <= `DGPIO_RESP_OKAY;
    end
    else if (do_write)
    begin
      bresp_q <= wr_hit ? `DGPIO_RESP_OKAY : `DGPIO_RESP_SLVERR;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register strobes into the two ports.
  assign pe_if.wr_data  = wdata_q;
  assign pf_if.wr_data  = wdata_q;
  assign pe_if.wr_latch = wr_en & (wr_idx == `DGPIO_IDX_PE_DATA);
  assign pf_if.wr_latch = wr_en & (wr_idx == `DGPIO_IDX_PF_DATA);
  assign pe_if.wr_dir   = wr_en & (wr_idx == `DGPIO_IDX_PE_DIR);
  assign pf_if.wr_dir   = wr_en & (wr_idx == `DGPIO_IDX_PF_DIR);
  assign pe_if.wr_led   = wr_en & (wr_idx == `DGPIO_IDX_PE_LED);
  assign pf_if.wr_led   = wr_en & (wr_idx == `DGPIO_IDX_PF_LED);
  assign pe_if.alt_sel  = lcd_frontplane_select;
  assign pe_if.alt_data = lcd_frontplane_outputs;
  assign pf_if.alt_sel  = 1'b0;
  assign pf_if.alt_data = `DGPIO_PIN_RST;
  assign pe_if.pin_in   = port_e_pin_in;
  assign pf_if.pin_in   = port_f_pin_in;

  dgpio_port u_port_e (
    .clk  (clk),
    .rstn (rstn),
    .bus  (pe_if)
  );

  dgpio_port u_port_f (
    .clk  (clk),
    .rstn (rstn),
    .bus  (pf_if)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read channel: data are captured on the address handshake.
  assign ar_take  = arvalid & arready_q;
  assign rvalid_d = ar_take | (rvalid_q & ~rready);
  assign rd_idx   = araddr[`DGPIO_IDX_MSB:`DGPIO_IDX_LSB];

  always_comb
  begin
    rd_hit = 1'b1;
    case (rd_idx)
      `DGPIO_IDX_PE_DATA: rd_val = pe_if.rd_value;
      `DGPIO_IDX_PF_DATA: rd_val = pf_if.rd_value;
      `DGPIO_IDX_PE_DIR:  rd_val = pe_if.dir;
      `DGPIO_IDX_PF_DIR:  rd_val = pf_if.dir;
      `DGPIO_IDX_PE_LED:  rd_val = pe_if.led;
      `DGPIO_IDX_PF_LED:  rd_val = pf_if.led;
      default:
      begin
        rd_val = `DGPIO_PIN_RST;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      arready_q <= 1'b0;
    end
    else
    begin
      arready_q <= ~ar_take & ~rvalid_d;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rvalid_q <= 1'b0;
    end
    else
    begin
      rvalid_q <= rvalid_d;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rdata_q <= '0;
    end
    else if (ar_take)
    begin
      rdata_q <= {{`DGPIO_PAD_W{1'b0}}, rd_val};
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rresp_q <= `DGPIO_RESP_OKAY;
    end
    else if (ar_take)
    begin
      rresp_q <= rd_hit ? `DGPIO_RESP_OKAY : `DGPIO_RESP_SLVERR;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign awready          = awready_q;
  assign wready           = wready_q;
  assign bvalid           = bvalid_q;
  assign bresp            = bresp_q;
  assign arready          = arready_q;
  assign rvalid           = rvalid_q;
  assign rresp            = rresp_q;
  assign rdata            = rdata_q;
  assign port_e_pin_out   = pe_if.pin_out;
  assign port_e_pin_oe    = pe_if.pin_oe;
  assign port_e_led_drive = pe_if.led_drive;
  assign port_f_pin_out   = pf_if.pin_out;
  assign port_f_pin_oe    = pf_if.pin_oe;
  assign port_f_led_drive = pf_if.led_drive;

endmodule

// *** bench/dgpio_assertions.sv ***
`include "dgpio_defs.svh"

module dgpio_assertions (
  input wire logic                     clk,
  input wire logic                     rstn,
  input wire logic                     awvalid,
  input wire logic                     awready,
  input wire logic                     wvalid,
  input wire logic                     wready,
  input wire logic                     bvalid,
  input wire logic                     arvalid,
  input wire logic                     arready,
  input wire logic                     rvalid,
  input wire logic [`DGPIO_DATA_W-1:0] rdata,
  input wire logic                     lcd_frontplane_select,
  input wire logic [`DGPIO_BYTE_W-1:0] lcd_frontplane_outputs,
  input wire logic [`DGPIO_BYTE_W-1:0] port_e_pin_out,
  input wire logic [`DGPIO_BYTE_W-1:0] port_e_pin_oe,
  input wire logic [`DGPIO_BYTE_W-1:0] port_e_led_drive,
  input wire logic [`DGPIO_BYTE_W-1:0] port_f_pin_oe,
  input wire logic [`DGPIO_BYTE_W-1:0] port_f_led_drive
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence aw_w_taken;
    awvalid && awready && wvalid && wready;
  endsequence

  sequence lcd_held;
    lcd_frontplane_select [*2];
  endsequence

  a_reset_clears_dir:
    assert property ($rose(rstn) |-> (port_e_pin_oe | port_f_pin_oe) == 8'h00)
    else $error("Pin driven right after reset.");
  a_write_answer:
    assert property (aw_w_taken |-> ##[1:3] bvalid) else $error("No write response.");
  a_write_refused:
    assert property (bvalid |-> !(awready || wready)) else $error("Write taken while busy.");
  a_read_answer:
    assert property (arvalid && arready |-> ##[1:2] rvalid) else $error("No read data.");
  a_read_refused:
    assert property (rvalid |-> !arready) else $error("Read taken while busy.");
  a_rdata_low_byte:
    assert property (rvalid |-> rdata[31:8] == 24'h000000) else $error("Upper read bits set.");
  a_lcd_owns_pins:
    assert property (lcd_held |-> port_e_pin_oe == 8'hff && port_e_led_drive == 8'h00
                     && port_e_pin_out == $past(lcd_frontplane_outputs))
    else $error("Port E pins not given to the display.");
  a_pins_need_write:
    assert property ($changed(port_f_pin_oe) || $changed(port_f_led_drive) |-> $past(bvalid))
    else $error("Pin control changed without a write.");
endmodule

bind dgpio_top dgpio_assertions u_chk (.clk, .rstn, .awvalid, .awready, .wvalid, .wready,
  .bvalid, .arvalid, .arready, .rvalid, .rdata, .lcd_frontplane_select, .lcd_frontplane_outputs,
  .port_e_pin_out, .port_e_pin_oe, .port_e_led_drive, .port_f_pin_oe, .port_f_led_drive);

// *** bench/dgpio_pin_model.sv ***
module dgpio_pin_model (
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] ext_level,
  output logic      [7:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;

  // A driven pin shows the port's level, a released pin the load's level.
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule

// *** bench/tb.sv ***
`include "dgpio_defs.svh"

module tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk = 1'b0, rstn = 1'b0, lcd_sel = 1'b0;
  logic [5:0]  awaddr = 6'h00, araddr = 6'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [3:0]  wstrb = 4'h1;
  logic [7:0]  ext_e = 8'hc3, ext_f = 8'h3c, e_in, e_out, e_oe, e_led, f_in, f_out, f_oe, f_led;
  int          fails = 0, checked = 0, cycles = 0;

  always #12.5 clk = ~clk;

  dgpio_top uut (.clk, .rstn, .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot(3'h0),
    .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .lcd_frontplane_select(lcd_sel),
    .lcd_frontplane_outputs(8'h96), .port_e_pin_in(e_in), .port_e_pin_out(e_out),
    .port_e_pin_oe(e_oe), .port_e_led_drive(e_led), .port_f_pin_in(f_in),
    .port_f_pin_out(f_out), .port_f_pin_oe(f_oe), .port_f_led_drive(f_led));
  dgpio_pin_model pm_e (.pin_out(e_out), .pin_oe(e_oe), .ext_level(ext_e), .pin_in(e_in));
  dgpio_pin_model pm_f (.pin_out(f_out), .pin_oe(f_oe), .ext_level(ext_f), .pin_in(f_in));

  ////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("checked %0d, fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      fails++;
      report_and_stop();
    end
  end

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    chk_byte({6'h00, got}, {6'h00, exp});
  endtask

  ////////////////////////////////////////////////////////////////
  task automatic wr(input logic [3:0] idx, input logic [7:0] d, input logic [1:0] er);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    chk_resp(bresp, er);
  endtask

  task automatic rc(input logic [3:0] idx, input logic [7:0] exp, input logic [1:0] er);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    chk_resp(rresp, er);
    chk_byte(rdata[7:0], exp);
  endtask

  ////////////////////////////////////////////////////////////////
  task automatic t_port(input logic is_f);
    logic [3:0] di;
    logic [3:0] ri;
    logic [7:0] x;
    di = is_f ? `DGPIO_IDX_PF_DATA : `DGPIO_IDX_PE_DATA;
    ri = is_f ? `DGPIO_IDX_PF_DIR : `DGPIO_IDX_PE_DIR;
    x = is_f ? ext_f : ext_e;
    rc(ri, `DGPIO_DIR_RST, `DGPIO_RESP_OKAY);
    wr(di, 8'ha5, `DGPIO_RESP_OKAY);
    rc(di, x, `DGPIO_RESP_OKAY);
    wr(ri, 8'h0f, `DGPIO_RESP_OKAY);
    rc(di, (8'h0f & 8'ha5) | (8'hf0 & x), `DGPIO_RESP_OKAY);
    rc(ri, 8'h0f, `DGPIO_RESP_OKAY);
    @(posedge clk);
    chk_byte(is_f ? f_oe : e_oe, 8'h0f);
    chk_byte(is_f ? f_out : e_out, 8'ha5);
    $display("port test %0d done", is_f);
  endtask

  task automatic t_lcd();
    lcd_sel <= 1'b1;
    repeat (2) @(posedge clk);
    chk_byte(e_oe, 8'hff);
    chk_byte(e_out, 8'h96);
    lcd_sel <= 1'b0;
    repeat (2) @(posedge clk);
    chk_byte(e_oe, 8'h0f);
    $display("display test done");
  endtask

  task automatic t_led();
    wr(`DGPIO_IDX_PF_DIR, 8'hff, `DGPIO_RESP_OKAY);
    wr(`DGPIO_IDX_PF_LED, 8'h81, `DGPIO_RESP_OKAY);
    wr(`DGPIO_IDX_PE_DIR, 8'hff, `DGPIO_RESP_OKAY);
    wr(`DGPIO_IDX_PE_LED, 8'h18, `DGPIO_RESP_OKAY);
    rc(`DGPIO_IDX_PF_LED, 8'h81, `DGPIO_RESP_OKAY);
    rc(`DGPIO_IDX_PE_LED, 8'h18, `DGPIO_RESP_OKAY);
    chk_byte(f_led, 8'h81);
    chk_byte(e_led, 8'h18);
    lcd_sel <= 1'b1;
    repeat (2) @(posedge clk);
    chk_byte(e_led, 8'h00);
    lcd_sel <= 1'b0;
    repeat (2) @(posedge clk);
    chk_byte(e_led, 8'h18);
    $display("drive test done");
  endtask

  task automatic t_misc();
    rc(4'h1, 8'h00, `DGPIO_RESP_SLVERR);
    wr(4'h1, 8'hff, `DGPIO_RESP_SLVERR);
    wstrb <= 4'h0;
    wr(`DGPIO_IDX_PF_LED, 8'h00, `DGPIO_RESP_OKAY);
    wstrb <= 4'h1;
    rc(`DGPIO_IDX_PF_LED, 8'h81, `DGPIO_RESP_OKAY);
    rstn <= 1'b0;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    chk_byte(e_oe | f_oe, 8'h00);
    rc(`DGPIO_IDX_PE_LED, `DGPIO_LED_RST, `DGPIO_RESP_OKAY);
    rc(`DGPIO_IDX_PF_DIR, `DGPIO_DIR_RST, `DGPIO_RESP_OKAY);
    wr(`DGPIO_IDX_PE_DIR, 8'hff, `DGPIO_RESP_OKAY);
    rc(`DGPIO_IDX_PE_DATA, 8'ha5, `DGPIO_RESP_OKAY);
    wr(`DGPIO_IDX_PF_DIR, 8'hff, `DGPIO_RESP_OKAY);
    rc(`DGPIO_IDX_PF_DATA, 8'ha5, `DGPIO_RESP_OKAY);
    $display("unmapped and reset test done");
  endtask

  initial
  begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_port(1'b0);
    t_port(1'b1);
    t_lcd();
    t_led();
    t_misc();
    report_and_stop();
  end
endmodule
